// [src/cins_defs.svh]
// constants for the instruction execution core
`ifndef CINS_DEFS_SVH
`define CINS_DEFS_SVH
// opcode patterns
`define CINS_OP_NOP 16'h0000
`define CINS_OP_RESET 16'h00FF
`define CINS_OP_POP 16'h0006
`define CINS_OP_PUSH 16'h0005
`define CINS_OP_IRET 15'h0008
`define CINS_OP_RETURN 15'h0009
`define CINS_OP_LRET 8'h0C
`define CINS_OP_CALLR 5'h1B
`define CINS_OP_NEG 7'h36
`define CINS_OP_ROTC 6'h0D
`define CINS_OP_ROTP 6'h11
// instruction field positions
`define CINS_HI15 15:1
`define CINS_HI8 15:8
`define CINS_HI7 15:9
`define CINS_HI6 15:10
`define CINS_HI5 15:11
`define CINS_F_RANGE 7:0
`define CINS_K_RANGE 7:0
`define CINS_N_RANGE 10:0
`define CINS_N_SIGN 10
`define CINS_D_BIT 9
`define CINS_A_BIT 8
`define CINS_S_BIT 0
`define CINS_MSB 7
`define CINS_LOW7 6:0
`define CINS_NIB 3:0
// addressing modes
`define CINS_ILO_MAX 8'h5F
`define CINS_ACC_SPLIT 8'h60
`define CINS_ACC_HIGH 4'hF
`define CINS_ACC_LOW 4'h0
// register offsets (byte addresses)
`define CINS_REG_CTRL 8'h00
`define CINS_REG_W 8'h04
`define CINS_REG_STATUS 8'h08
`define CINS_REG_BANK 8'h0C
`define CINS_REG_PC 8'h10
`define CINS_REG_TOP 8'h14
`define CINS_REG_SP 8'h18
`define CINS_REG_FSR2 8'h1C
`define CINS_REG_INTEN 8'h20
`define CINS_REG_SHADOW 8'h24
// register bits
`define CINS_CTRL_EXT 0
`define CINS_GIE_H 0
`define CINS_GIE_L 1
// reset values and steps
`define CINS_W_RST 8'h00
`define CINS_BANK_RST 4'h0
`define CINS_FSR_RST 12'h000
`define CINS_PC_STEP 2
`endif

// [src/cins_pkg.sv]
// types shared by the instruction execution core
package cins_pkg;
  // status flags, c in bit 0 up to n in bit 4
  typedef struct packed {
    logic n;
    logic ov;
    logic z;
    logic dc;
    logic c;
  } cins_flags_t;
  // registered file-register write port
  typedef struct packed {
    logic we;
    logic [11:0] addr;
    logic [7:0] data;
  } cins_fwr_t;
  // layout of the shadow register word
  typedef struct packed {
    logic [11:0] rsv_hi;
    logic [3:0] bank;
    logic [2:0] rsv_lo;
    cins_flags_t flags;
    logic [7:0] w;
  } cins_shadow_t;
  // execute or dead second cycle (gray)
  typedef enum logic [0:0] {
    CINS_ST_EXEC = 1'b0,
    CINS_ST_SECOND = 1'b1
  } cins_state_t;
endpackage

// [src/cins_core.sv]
// instruction execution core: negate, stack, calls, returns, rotates
//
// The address-and-strobe port and the register offsets are this design's own decisions.
`timescale 1ns/100ps
`include "cins_defs.svh"
// Functional notes
// - negate file register, update five flags
// - access bit picks access bank or bank
// - extended set, small operand: indexed literal offset
// - destination bit picks working or file
// - pop drops top entry, flags kept
// - push stores pc plus two on top
// - relative call pushes, jumps, two cycles
// - software reset equals master reset pin
// - interrupt return pops pc, sets enable
// - subroutine return pops pc, two cycles
// - shadow bit restores working, status, bank
// - literal return loads working, pops pc
// - rotate left through carry, three flags
// - rotate left plain, negative and zero
module cins_core #(
  parameter int STACK_DEPTH = 31,
  parameter int PC_W = 21
) (
  // clock, reset, enable
  input wire logic clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic master_reset_pin_n,
  // instruction stream
  input wire logic instr_valid,
  input wire logic [15:0] instr,
  output logic instr_ready,
  // file register memory
  output logic [11:0] file_raddr,
  input wire logic [7:0] file_rdata,
  output cins_pkg::cins_fwr_t file_wr,
  // register port
  input wire logic [7:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [31:0] reg_rdata
);
  import cins_pkg::*;

  localparam int SPW = $clog2(STACK_DEPTH + 1);

  // refuse shapes the logic cannot serve
  if (STACK_DEPTH < 1 || STACK_DEPTH > 255 || PC_W < 12 || PC_W > 32) begin : g_bad
    $error("cins_core: unsupported stack depth or pc width");
  end

  // pc plus one instruction word
  function automatic logic [PC_W-1:0] pc_plus2(input logic [PC_W-1:0] p);
    return p + PC_W'(`CINS_PC_STEP);
  endfunction

  // effective file address from operand, access bit and mode
  function automatic logic [11:0] form_addr(input logic [7:0] f, input logic a,
      input logic ext, input logic [3:0] bank, input logic [11:0] fsr2);
    if (a) begin
      return {bank, f};
    end else if (ext && f <= `CINS_ILO_MAX) begin
      return fsr2 + {`CINS_ACC_LOW, f};
    end else if (f < `CINS_ACC_SPLIT) begin
      return {`CINS_ACC_LOW, f};
    end else begin
      return {`CINS_ACC_HIGH, f};
    end
  endfunction

  // architectural state
  logic prst_s1_q; // first sync stage, read only by the second
  logic prst_s2_q;
  cins_state_t state_q;
  logic [PC_W-1:0] pc_q;
  logic [PC_W-1:0] stk_q [STACK_DEPTH]; // return stack storage
  logic [SPW-1:0] sp_q; // entries held
  logic [7:0] w_q;
  cins_flags_t status_q;
  logic [3:0] bank_q;
  logic [7:0] w_sh_q;
  cins_flags_t status_sh_q;
  logic [3:0] bank_sh_q;
  logic gie_hi_q;
  logic gie_lo_q;
  logic ext_q; // extended instruction set enable
  logic [11:0] fsr2_q;
  cins_fwr_t fwr_q;
  logic [31:0] rdata_q;

  // decode and datapath
  logic exec;
  logic rst_hw;
  logic rst_all;
  logic is_nop, is_reset, is_pop, is_push, is_rel_call, is_int_ret, is_return;
  logic is_lit_ret, is_neg, is_rot_c, is_rot_p, is_ret_any, is_rot;
  logic do_push, do_pop, dest_file, shadow_sel, stk_full, stk_empty;
  logic [7:0] fval;
  logic [7:0] neg_res;
  logic [8:0] neg_sum;
  logic [4:0] neg_nib;
  logic [7:0] rot_carry;
  logic [7:0] rot_plain;
  logic [PC_W-1:0] stk_top;
  logic [PC_W-1:0] call_tgt;
  logic bus_w, bus_status, bus_bank, bus_shadow;
  cins_shadow_t shw;

  assign instr_ready = (state_q == CINS_ST_EXEC);
  assign exec = ce & instr_valid & instr_ready;

  // opcode decode
  assign is_nop = (instr == `CINS_OP_NOP);
  assign is_reset = (instr == `CINS_OP_RESET);
  assign is_pop = (instr == `CINS_OP_POP);
  assign is_push = (instr == `CINS_OP_PUSH);
  assign is_int_ret = (instr[`CINS_HI15] == `CINS_OP_IRET);
  assign is_return = (instr[`CINS_HI15] == `CINS_OP_RETURN);
  assign is_lit_ret = (instr[`CINS_HI8] == `CINS_OP_LRET);
  assign is_rel_call = (instr[`CINS_HI5] == `CINS_OP_CALLR);
  assign is_neg = (instr[`CINS_HI7] == `CINS_OP_NEG);
  assign is_rot_c = (instr[`CINS_HI6] == `CINS_OP_ROTC);
  assign is_rot_p = (instr[`CINS_HI6] == `CINS_OP_ROTP);
  assign is_ret_any = is_int_ret | is_return | is_lit_ret;
  assign is_rot = is_rot_c | is_rot_p;
  assign do_push = is_push | is_rel_call;
  assign do_pop = is_pop | is_ret_any;
  assign dest_file = instr[`CINS_D_BIT];
  assign shadow_sel = instr[`CINS_S_BIT] & (is_int_ret | is_return);
  assign stk_full = (sp_q == SPW'(STACK_DEPTH));
  assign stk_empty = (sp_q == '0);
  assign stk_top = stk_empty ? '0 : stk_q[sp_q - 1'b1];

  // operand address: bank, access bank or indexed literal offset
  assign file_raddr = form_addr(instr[`CINS_F_RANGE], instr[`CINS_A_BIT], ext_q,
                                bank_q, fsr2_q);
  assign fval = file_rdata;

  // negate as invert plus one so carries fall out of the adder
  assign neg_sum = {1'b0, ~fval} + 9'h001;
  assign neg_nib = {1'b0, ~fval[`CINS_NIB]} + 5'h01;
  assign neg_res = neg_sum[`CINS_F_RANGE];
  assign rot_carry = {fval[`CINS_LOW7], status_q.c};
  assign rot_plain = {fval[`CINS_LOW7], fval[`CINS_MSB]};
  // sign-extended doubled offset
  assign call_tgt = pc_plus2(pc_q)
      + {{(PC_W-12){instr[`CINS_N_SIGN]}}, instr[`CINS_N_RANGE], 1'b0};

  // hardware resets: port, pin; software reset joins them
  assign rst_hw = rst | ~prst_s2_q;
  assign rst_all = rst_hw | (exec & is_reset);

  // bus writes, which an executing instruction in the same cycle overrides
  assign bus_w = reg_wr & (reg_addr == `CINS_REG_W);
  assign bus_status = reg_wr & (reg_addr == `CINS_REG_STATUS);
  assign bus_bank = reg_wr & (reg_addr == `CINS_REG_BANK);
  assign bus_shadow = reg_wr & (reg_addr == `CINS_REG_SHADOW);
  assign shw = cins_shadow_t'(reg_wdata);

  // master reset pin synchroniser, only the port reset clears it
  always_ff @(posedge clk) begin
    if (rst) begin
      prst_s1_q <= 1'b1;
      prst_s2_q <= 1'b1;
    end else if (ce) begin
      prst_s1_q <= master_reset_pin_n;
      prst_s2_q <= prst_s1_q;
    end
  end

  // second cycle of calls and returns is a dead slot
  always_ff @(posedge clk) begin
    if (rst_all) begin
      state_q <= CINS_ST_EXEC;
    end else if (ce) begin
      case (state_q)
        CINS_ST_EXEC: begin
          if (exec && (is_rel_call || is_ret_any)) begin
            state_q <= CINS_ST_SECOND;
          end
        end
        CINS_ST_SECOND: state_q <= CINS_ST_EXEC;
        default: state_q <= CINS_ST_EXEC;
      endcase
    end
  end

  // program counter; returns load it from the stack top
  always_ff @(posedge clk) begin
    if (rst_all) begin
      pc_q <= '0;
    end else if (exec) begin
      if (is_rel_call) begin
        pc_q <= call_tgt;
      end else if (is_ret_any) begin
        pc_q <= stk_top;
      end else begin
        pc_q <= pc_plus2(pc_q);
      end
    end
  end

  // stack pointer; overflow and underflow are simply held
  always_ff @(posedge clk) begin
    if (rst_all) begin
      sp_q <= '0;
    end else if (exec) begin
      if (do_push && !stk_full) begin
        sp_q <= sp_q + 1'b1;
      end else if (do_pop && !stk_empty) begin
        sp_q <= sp_q - 1'b1;
      end
    end
  end

  // stack contents are data and need no reset
  always_ff @(posedge clk) begin
    if (exec && !rst_all && do_push && !stk_full) begin
      stk_q[sp_q] <= pc_plus2(pc_q);
    end
  end

  // working register
  always_ff @(posedge clk) begin
    if (rst_all) begin
      w_q <= `CINS_W_RST;
    end else if (exec && is_lit_ret) begin
      w_q <= instr[`CINS_K_RANGE];
    end else if (exec && shadow_sel) begin
      w_q <= w_sh_q;
    end else if (exec && is_rot && !dest_file) begin
      w_q <= is_rot_c ? rot_carry : rot_plain;
    end else if (ce && bus_w) begin
      w_q <= reg_wdata[`CINS_K_RANGE];
    end
  end

  // status flags
  always_ff @(posedge clk) begin
    if (rst_all) begin
      status_q <= '0;
    end else if (exec && is_neg) begin
      status_q.c <= neg_sum[8];
      status_q.dc <= neg_nib[4];
      status_q.ov <= fval[`CINS_MSB] & neg_res[`CINS_MSB];
      status_q.n <= neg_res[`CINS_MSB];
      status_q.z <= (neg_res == 8'h00);
    end else if (exec && is_rot_c) begin
      status_q.c <= fval[`CINS_MSB];
      status_q.n <= rot_carry[`CINS_MSB];
      status_q.z <= (rot_carry == 8'h00);
    end else if (exec && is_rot_p) begin
      status_q.n <= rot_plain[`CINS_MSB];
      status_q.z <= (rot_plain == 8'h00);
    end else if (exec && shadow_sel) begin
      status_q <= status_sh_q;
    end else if (ce && bus_status) begin
      status_q <= cins_flags_t'(reg_wdata[4:0]);
    end
  end

  // bank select
  always_ff @(posedge clk) begin
    if (rst_all) begin
      bank_q <= `CINS_BANK_RST;
    end else if (exec && shadow_sel) begin
      bank_q <= bank_sh_q;
    end else if (ce && bus_bank) begin
      bank_q <= reg_wdata[`CINS_NIB];
    end
  end

  // shadow copies, loaded only by software here
  always_ff @(posedge clk) begin
    if (rst_all) begin
      w_sh_q <= `CINS_W_RST;
      status_sh_q <= '0;
      bank_sh_q <= `CINS_BANK_RST;
    end else if (ce && bus_shadow) begin
      w_sh_q <= shw.w;
      status_sh_q <= shw.flags;
      bank_sh_q <= shw.bank;
    end
  end

  // global enables: interrupt return sets high first, then low
  always_ff @(posedge clk) begin
    if (rst_all) begin
      gie_hi_q <= 1'b0;
      gie_lo_q <= 1'b0;
    end else if (exec && is_int_ret) begin
      if (!gie_hi_q) begin
        gie_hi_q <= 1'b1;
      end else begin
        gie_lo_q <= 1'b1;
      end
    end else if (ce && reg_wr && reg_addr == `CINS_REG_INTEN) begin
      gie_hi_q <= reg_wdata[`CINS_GIE_H];
      gie_lo_q <= reg_wdata[`CINS_GIE_L];
    end
  end

  // mode and index pointer written by software
  always_ff @(posedge clk) begin
    if (rst_all) begin
      ext_q <= 1'b0;
      fsr2_q <= `CINS_FSR_RST;
    end else if (ce && reg_wr) begin
      if (reg_addr == `CINS_REG_CTRL) begin
        ext_q <= reg_wdata[`CINS_CTRL_EXT];
      end
      if (reg_addr == `CINS_REG_FSR2) begin
        fsr2_q <= reg_wdata[11:0];
      end
    end
  end

  // file write is registered; memory sees it one cycle late
  always_ff @(posedge clk) begin
    if (rst_all) begin
      fwr_q <= '0;
    end else if (ce) begin
      fwr_q.we <= exec & (is_neg | (is_rot & dest_file));
      fwr_q.addr <= file_raddr;
      fwr_q.data <= is_neg ? neg_res : (is_rot_c ? rot_carry : rot_plain);
    end
  end
  assign file_wr = fwr_q;

  // read data stands only in the cycle after the strobe
  always_ff @(posedge clk) begin
    if (rst_all) begin
      rdata_q <= '0;
    end else if (ce) begin
      rdata_q <= '0;
      if (reg_rd) begin
        case (reg_addr)
          `CINS_REG_CTRL: rdata_q <= 32'(ext_q);
          `CINS_REG_W: rdata_q <= 32'(w_q);
          `CINS_REG_STATUS: rdata_q <= 32'(status_q);
          `CINS_REG_BANK: rdata_q <= 32'(bank_q);
          `CINS_REG_PC: rdata_q <= 32'(pc_q);
          `CINS_REG_TOP: rdata_q <= 32'(stk_top);
          `CINS_REG_SP: rdata_q <= 32'(sp_q);
          `CINS_REG_FSR2: rdata_q <= 32'(fsr2_q);
          `CINS_REG_INTEN: rdata_q <= 32'({gie_lo_q, gie_hi_q});
          `CINS_REG_SHADOW: rdata_q <= 32'({bank_sh_q, 3'h0, status_sh_q, w_sh_q});
          default: rdata_q <= '0; // unmapped reads as zero
        endcase
      end
    end
  end
  assign reg_rdata = rdata_q;

  // checks on the executed instructions
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst_hw);

  sequence s_dead_slot;
    !instr_ready;
  endsequence

  a_negate_write: assert property (exec && is_neg |=> file_wr.we &&
      file_wr.data == $past(neg_res) && status_q.n == file_wr.data[7])
    else $error("negate result or flags wrong");
  a_bank_address: assert property (instr[`CINS_A_BIT] |->
      file_raddr == {bank_q, instr[`CINS_F_RANGE]})
    else $error("bank address not formed from bank select");
  a_pop_keeps_flags: assert property (exec && is_pop && !stk_empty |=>
      sp_q == $past(sp_q) - 1'b1 && status_q == $past(status_q))
    else $error("pop did not drop one entry cleanly");
  a_push_top_value: assert property (exec && is_push && !stk_full |=>
      stk_top == $past(pc_q) + PC_W'(2) && sp_q == $past(sp_q) + 1'b1)
    else $error("push stored wrong value");
  a_call_jump: assert property (exec && is_rel_call && !stk_full |=>
      pc_q == $past(call_tgt) && stk_top == $past(pc_q) + PC_W'(2) ##0 s_dead_slot)
    else $error("relative call target or slot wrong");
  a_return_pops_pc: assert property (exec && is_ret_any && !stk_empty |=>
      pc_q == $past(stk_top) ##0 s_dead_slot)
    else $error("return did not load pc from stack");
  a_shadow_restore: assert property (exec && shadow_sel |=>
      w_q == $past(w_sh_q) && bank_q == $past(bank_sh_q) && status_q == $past(status_sh_q))
    else $error("shadow restore failed");
  a_literal_return: assert property (exec && is_lit_ret |=>
      w_q == $past(instr[`CINS_K_RANGE]))
    else $error("literal not loaded into working register");
  a_rotate_carry: assert property (exec && is_rot_c |=>
      status_q.c == $past(fval[`CINS_MSB]))
    else $error("rotate through carry lost bit 7");
  a_plain_rotate_c: assert property (exec && is_rot_p && !dest_file |=>
      status_q.c == $past(status_q.c) && w_q == $past(rot_plain) && !file_wr.we)
    else $error("plain rotate touched carry or wrong target");
  a_nop_advance: assert property (exec && is_nop |=>
      pc_q == $past(pc_q) + PC_W'(2) && w_q == $past(w_q) && sp_q == $past(sp_q))
    else $error("nop changed state");
  a_soft_reset: assert property (exec && is_reset |=>
      pc_q == '0 && w_q == '0 && sp_q == '0 && !ext_q)
    else $error("software reset incomplete");
endmodule

// [dv/cins_core_tb.sv]
// self-checking bench for the instruction execution core
`timescale 1ns/100ps
module cins_core_tb;
  import cins_pkg::*;
  localparam int PC_W = 21;
  localparam int LIMIT = 20000; // cycle ceiling, well above the run
  // clock, resets and stimulus
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic ce = 1'b1; // tied: freezing is not exercised
  logic master_reset_pin_n = 1'b1;
  logic instr_valid = 1'b0;
  logic [15:0] instr = 16'h0000;
  logic instr_ready;
  logic [11:0] file_raddr;
  logic [7:0] file_rdata;
  cins_fwr_t file_wr;
  logic [7:0] reg_addr = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [31:0] reg_rdata;
  // far-side memory and result notes
  logic [7:0] mem [4096];
  logic [31:0] rq [$];
  logic [19:0] fq [$];
  logic [PC_W-1:0] stk [$];
  logic rd_pend = 1'b0;
  int mismatches = 0;
  int checks_done = 0;
  int cyc = 0;
  // expected core state
  logic [7:0] ew;
  logic [4:0] es;
  logic [3:0] ebsr;
  logic [1:0] einten;
  logic [PC_W-1:0] epc;
  logic [7:0] v;
  logic [7:0] f;
  logic [7:0] r;
  logic a;
  logic [10:0] n;
  logic [15:0] rets [5] = '{16'h0013, 16'h0C7E, 16'h0010, 16'h0011, 16'h0012};
  logic [7:0] maps [10] = '{8'h00, 8'h04, 8'h08, 8'h0C, 8'h10, 8'h14, 8'h18, 8'h1C, 8'h20, 8'h24};

  cins_core #(.STACK_DEPTH(31), .PC_W(PC_W)) dut_u (
    .clk(clk), .rst(rst), .ce(ce), .master_reset_pin_n(master_reset_pin_n),
    .instr_valid(instr_valid), .instr(instr), .instr_ready(instr_ready),
    .file_raddr(file_raddr), .file_rdata(file_rdata), .file_wr(file_wr),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata));

  // clock, 20 ns period
  always #10 clk = ~clk;
  // combinational memory, written by the core's registered port
  assign file_rdata = mem[file_raddr];
  always @(posedge clk) if (file_wr.we === 1'b1) mem[file_wr.addr] <= file_wr.data;

  // shared report of one comparison
  task automatic note(input logic ok, input logic [31:0] got, input logic [31:0] exp);
    checks_done++;
    if (!ok) begin
      mismatches++;
      $display("Error at %0t: got %0h expected %0h", $time, got, exp);
    end
  endtask
  task automatic cmp_reg(input logic [31:0] g, input logic [31:0] e);
    note(g === e, g, e);
  endtask
  task automatic cmp_file(input logic [19:0] g, input logic [19:0] e);
    note(g === e, {12'h0, g}, {12'h0, e});
  endtask
  task automatic cmp_bit(input logic g, input logic e);
    note(g === e, {31'h0, g}, {31'h0, e});
  endtask

  // watcher: read data one cycle after the strobe, file write pulses
  always @(posedge clk) begin
    cyc++;
    if (rd_pend) cmp_reg(reg_rdata, rq.pop_front());
    rd_pend <= reg_rd;
    if (!rst && file_wr.we !== 1'b0)
      cmp_file({file_wr.addr, file_wr.data}, (fq.size() > 0) ? fq.pop_front() : 20'hFFFFF);
    if (cyc == LIMIT) begin
      mismatches++;
      end_of_test();
    end
  end

  // register port: one-cycle strobes, an idle cycle after each
  task automatic wr(input logic [7:0] ad, input logic [31:0] d);
    reg_addr <= ad;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge clk);
    reg_wr <= 1'b0;
    @(posedge clk);
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] e);
    reg_addr <= ad;
    reg_rd <= 1'b1;
    rq.push_back(e);
    @(posedge clk);
    reg_rd <= 1'b0;
    @(posedge clk);
  endtask
  // one instruction; the cycle after must refuse only for two-cycle ops
  task automatic ex(input logic [15:0] w, input logic dead);
    instr <= w;
    instr_valid <= 1'b1;
    @(posedge clk);
    instr_valid <= 1'b0;
    @(negedge clk);
    cmp_bit(instr_ready, !dead);
    @(posedge clk);
  endtask
  // every mapped register and one unmapped place must read zero
  task automatic all_zero();
    foreach (maps[i]) rd(maps[i], 32'h0);
    rd(8'h3C, 32'h0);
  endtask
  // operand address the core must form
  function automatic logic [11:0] fa(input logic [7:0] ff, input logic aa, input logic ext);
    if (aa) return {ebsr, ff};
    if (ext && ff <= 8'h5F) return 12'h123 + {4'h0, ff};
    return (ff < 8'h60) ? {4'h0, ff} : {4'hF, ff};
  endfunction
  task automatic regs_chk();
    rd(8'h10, {11'h0, epc});
    rd(8'h04, {24'h0, ew});
    rd(8'h08, {27'h0, es});
    rd(8'h0C, {28'h0, ebsr});
  endtask

  task automatic end_of_test();
    mismatches += rq.size() + fq.size();
    $display("checks %0d mismatches %0d", checks_done, mismatches);
    if (mismatches == 0 && checks_done > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    foreach (mem[i]) mem[i] = 8'h00;
    void'($urandom(11309));
    repeat (3) @(posedge clk);
    rst <= 1'b0;
    // test 1: values out of reset, read-only pc
    all_zero();
    wr(8'h10, 32'h0000_1234);
    rd(8'h10, 32'h0);
    epc = 0;
    ebsr = 4'h5;
    einten = 2'b00;
    wr(8'h0C, 32'h5);
    wr(8'h1C, 32'h123);
    $display("test 1 done");
    // test 2: negate over every addressing mode and flag corner
    for (int i = 0; i < 8; i++) begin
      v = (i < 6) ? 8'h00 + {8'h00, 8'h80, 8'h01, 8'h7F, 8'h3A, 8'h10} >> (8 * (5 - i)) : 8'($urandom);
      a = (i % 4 == 0);
      f = (i % 4 == 1) ? 8'h5F : (i % 4 == 2) ? 8'h60 : 8'($urandom);
      wr(8'h00, {31'h0, i[2]});
      mem[fa(f, a, i[2])] = v;
      r = ~v + 8'h01;
      fq.push_back({fa(f, a, i[2]), r});
      es = {r[7], v == 8'h80, r == 8'h00, v[3:0] == 4'h0, v == 8'h00};
      ex({7'h36, a, f}, 1'b0);
      epc += 2;
      rd(8'h08, {27'h0, es});
    end
    $display("test 2 done");
    // test 3: rotates, both destinations, indexed and banked
    ew = 8'($urandom);
    wr(8'h04, {24'h0, ew});
    for (int i = 0; i < 8; i++) begin
      v = 8'($urandom);
      f = 8'($urandom);
      mem[fa(f, i[2], 1'b1)] = v;
      r = {v[6:0], i[0] ? v[7] : es[0]};
      if (!i[0]) es[0] = v[7];
      es[4] = r[7];
      es[2] = (r == 8'h00);
      if (i[1]) fq.push_back({fa(f, i[2], 1'b1), r});
      else ew = r;
      ex({i[0] ? 6'h11 : 6'h0D, i[1], i[2], f}, 1'b0);
      epc += 2;
      regs_chk();
    end
    $display("test 3 done");
    // test 4: push, pop and pop of an empty stack, flags kept
    wr(8'h08, 32'h15);
    es = 5'h15;
    for (int i = 0; i < 2; i++) begin
      stk.push_back(epc + 2);
      epc += 2;
      ex(16'h0005, 1'b0);
      rd(8'h14, {11'h0, stk[$]});
    end
    rd(8'h18, 32'h2);
    for (int i = 0; i < 3; i++) begin
      if (stk.size() > 0) void'(stk.pop_back());
      epc += 2;
      ex(16'h0006, 1'b0);
      rd(8'h14, (stk.size() > 0) ? {11'h0, stk[$]} : 32'h0);
      rd(8'h18, stk.size());
    end
    regs_chk();
    $display("test 4 done");
    // test 5: relative call at both offset limits and one random
    for (int i = 0; i < 3; i++) begin
      n = (i == 0) ? 11'h400 : (i == 1) ? 11'h3FF : 11'($urandom);
      stk.push_back(epc + 2);
      epc = epc + 2 + {{(PC_W - 11){n[10]}}, n} * 2;
      ex({5'h1B, n}, 1'b1);
      rd(8'h10, {11'h0, epc});
      rd(8'h14, {11'h0, stk[$]});
    end
    rd(8'h18, 32'h3);
    $display("test 5 done");
    // test 6: every return kind, with and without shadows
    wr(8'h24, 32'h000A_0B5C);
    wr(8'h04, 32'h33);
    ew = 8'h33;
    foreach (rets[i]) begin
      stk.push_back(epc + 2);
      epc += 2;
      ex(16'h0005, 1'b0);
      epc = stk.pop_back();
      if (rets[i][15:8] == 8'h0C) ew = rets[i][7:0];
      else if (rets[i][0]) begin
        ew = 8'h5C;
        es = 5'h0B;
        ebsr = 4'hA;
      end
      if (rets[i][15:1] == 15'h0008) einten |= einten[0] ? 2'b10 : 2'b01;
      ex(rets[i], 1'b1);
      regs_chk();
      rd(8'h20, {30'h0, einten});
      rd(8'h18, 32'h3);
    end
    $display("test 6 done");
    // test 7: no-operation only moves the program counter
    epc += 2;
    ex(16'h0000, 1'b0);
    regs_chk();
    rd(8'h18, 32'h3);
    $display("test 7 done");
    // test 8: software reset, then the external pin
    ex(16'h00FF, 1'b0);
    all_zero();
    wr(8'h04, 32'h44);
    master_reset_pin_n <= 1'b0;
    repeat (3) @(posedge clk);
    master_reset_pin_n <= 1'b1;
    repeat (4) @(posedge clk);
    all_zero();
    $display("test 8 done");
    repeat (3) @(posedge clk);
    end_of_test();
  end
endmodule
